// ===== logic/sbrf_pkg.sv
// package: constants and carrier types for the satellite report formatter
package sbrf_pkg;
  localparam int          SBRF_DATA_W      = 16;           // report word width
  localparam int          SBRF_FIFO_DEPTH  = 16;           // words held per buffer
  // register byte offsets
  localparam logic [7:0]  SBRF_CTRL_OFF    = 8'h00;        // channel setup, field length
  localparam logic [7:0]  SBRF_CH1_OFF     = 8'h04;        // channel 1 report pop
  localparam logic [7:0]  SBRF_CH2_OFF     = 8'h08;        // channel 2 report pop
  localparam logic [7:0]  SBRF_STAT_OFF    = 8'h0c;        // fill levels
  // control field positions
  localparam int          SBRF_CTRL_LEN_LSB = 0;           // field length, 4 bits
  localparam int          SBRF_CTRL_ST1_LSB = 4;           // channel 1 state, 2 bits
  localparam int          SBRF_CTRL_ST2_LSB = 6;           // channel 2 state, 2 bits
  localparam logic [31:0] SBRF_CTRL_RST    = 32'h0000_00eb; // ch1 state 10, ch2 state 11, length 11
  // field length limits
  localparam logic [3:0]  SBRF_LEN_MIN     = 4'h8;
  localparam logic [3:0]  SBRF_LEN_MAX     = 4'hb;
  // fault codes
  localparam logic [11:0] SBRF_CODE_FEW    = 12'h019;      // bit time error or too few bits
  localparam logic [11:0] SBRF_CODE_MANY   = 12'h01a;      // too many bits
  localparam logic [11:0] SBRF_CODE_PAR    = 12'h01c;      // satellite parity error
  localparam logic [15:0] SBRF_CH2_RST     = 16'he000;     // channel 2 word after reset
  // status pair in d15:d14
  typedef enum logic [1:0] {
    SBRF_ST_OFF    = 2'b00,
    SBRF_ST_NOPROC = 2'b01,
    SBRF_ST_PROC   = 2'b10,
    SBRF_ST_CFG    = 2'b11
  } sbrf_status_t;
  // one received message from the decoder
  typedef struct packed {
    logic        chan;       // 0 = channel 1, 1 = channel 2
    logic [4:0]  nbits;      // data field bits counted
    logic [10:0] data;       // bits, lsb-aligned
    logic        par_err;    // satellite parity error
    logic        time_err;   // manchester bit time error
  } sbrf_msg_t;
endpackage : sbrf_pkg

// ===== logic/sbrf_fifo.sv
// file: parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module sbrf_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];   // storage
  logic [AW-1:0]    wr_ptr;        // next write slot
  logic [AW-1:0]    rd_ptr;        // oldest slot
  logic             push;
  logic             pop;

  // honest flags straight from the level
  assign in_ready  = (level != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid = (level != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointers and level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + AW'(1);
      if (pop)
        rd_ptr <= rd_ptr + AW'(1);
      level <= level + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // storage has no reset; only written slots are ever read
  always_ff @(posedge pclk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  fifo_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
    level <= (AW+1)'(DEPTH)) else $error("fifo level above depth");
endmodule : sbrf_fifo
`default_nettype wire

// ===== logic/sbrf_formatter.sv
// file: satellite b protocol report formatter with apb register access
// Summary of operation
// - parity error reports fault code 1c
// - d11 one for data, zero for faults
// - field length settable from 8 to 11
// - data right justified, upper bits zero
// - more bits than length: too many
// - fewer bits than length: too few
// - channel 1 reports setup after reset
// - channel 2 returns e000 after reset
// - d15:d14 carry the channel state
// - d13 makes the word odd parity
// - d12 flags a write to full buffer
// - few/time error 19, many 1a
`timescale 1ns/1ns
`default_nettype none
module sbrf_formatter
  import sbrf_pkg::*;
#(
  parameter int DEPTH = SBRF_FIFO_DEPTH
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire sbrf_msg_t   msg,
  input  wire logic        msg_valid,
  output logic             msg_ready
);
  localparam int LW = $clog2(DEPTH) + 1;

  // how the block hangs together
  // - the decoder hands over one message per cycle with msg_valid
  // - the message is judged against the configured field length
  // - a fault replaces the payload by its code, with d11 low
  // - good data is masked to the field length, with d11 high
  // - status, loss flag and odd parity complete the 16-bit word
  // - the word is pushed into the buffer of its channel
  // - only a channel in the processing state stores words
  // - a read of a channel pops its buffer in the access cycle
  // - an empty buffer reads as status plus parity, no payload
  // - after reset each channel first shows its reset word
  //
  // loss handling
  // - a message for a full buffer is dropped, never stalled
  // - the drop sets a per-channel loss flag
  // - the flag is merged into d12 of the next word read out
  // - parity is recomputed at read time so d12 stays covered
  // - a pop clears the flag unless a new drop lands that cycle
  //
  // limitations
  // - the decoder cannot be held off: msg_ready is tied high
  // - field length writes outside 8..11 are refused whole,
  //   so the channel states in that write are not taken either
  // - the reset word of channel 1 follows the live setup register,
  //   so a setup write before the first read changes it
  //
  // bus timing
  // - answer registered in the setup cycle
  // - pready high in the first access cycle, no wait states
  // - the pop and the setup write take effect at that access edge

  logic [7:0]          ctrl;           // setup register
  logic [3:0]          field_len;      // configured data field length
  sbrf_status_t        st [2];         // per channel state
  logic [1:0]          boot;           // channel still shows its reset word
  logic [1:0]          lost;           // data lost flags, per channel
  logic [15:0]         word;           // formatted word for the incoming message
  logic [11:0]         body;           // d11:d0 content
  logic [15:0]         in_data [2];
  logic [1:0]          in_valid;
  logic [1:0]          in_ready;
  logic [15:0]         out_data [2];
  logic [1:0]          out_valid;
  logic [1:0]          out_ready;
  logic [LW-1:0]       level [2];
  logic                setup;          // apb setup phase
  logic                access;         // apb access phase, always ready
  logic                rd_ch [2];
  logic [15:0]         next_word;
  logic [1:0]          cfg_bits;

  assign field_len = ctrl[SBRF_CTRL_LEN_LSB +: 4];
  assign st[0]     = sbrf_status_t'(ctrl[SBRF_CTRL_ST1_LSB +: 2]);
  assign st[1]     = sbrf_status_t'(ctrl[SBRF_CTRL_ST2_LSB +: 2]);
  assign setup     = psel && !penable;
  assign access    = psel && penable;
  assign rd_ch[0]  = access && !pwrite && paddr == SBRF_CH1_OFF;
  assign rd_ch[1]  = access && !pwrite && paddr == SBRF_CH2_OFF;
  assign cfg_bits  = 2'b11;

  // fault priority: parity, then length checks, then time error
  always_comb
  begin
    body = {1'b1, 11'h000};
    if (msg.par_err)
      body = SBRF_CODE_PAR;
    else if (msg.nbits > {1'b0, field_len})
      body = SBRF_CODE_MANY;
    else if (msg.nbits < {1'b0, field_len} || msg.time_err)
      body = SBRF_CODE_FEW;
    else
      body = {1'b1, msg.data & ~(11'h7ff << field_len)};
  end

  // d15:d14 state, d12 loss, d13 chosen for odd parity
  always_comb
  begin
    next_word = {st[msg.chan], 1'b0, lost[msg.chan], body};
    next_word[13] = ~^next_word;
    word = next_word;
  end

  // the decoder is never stalled, msg_ready stays high;
  // a message for a full buffer is dropped and flagged
  assign msg_ready = 1'b1;

  // words go into the buffer of the addressed channel while it processes
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_ch
      assign in_valid[g]  = msg_valid && msg.chan == 1'(g) && st[g] == SBRF_ST_PROC;
      assign in_data[g]   = word;
      assign out_ready[g] = rd_ch[g] && !boot[g];
      sbrf_fifo #(.WIDTH(16), .DEPTH(DEPTH)) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_data   (in_data[g]),
        .in_valid  (in_valid[g]),
        .in_ready  (in_ready[g]),
        .out_data  (out_data[g]),
        .out_valid (out_valid[g]),
        .out_ready (out_ready[g]),
        .level     (level[g])
      );
    end
  endgenerate

  // data lost: set on a write to a full buffer, set wins over clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lost <= 2'b00;
    else
      for (int i = 0; i < 2; i++)
      begin
        if (in_valid[i] && !in_ready[i])
          lost[i] <= 1'b1;
        else if (out_ready[i])
          lost[i] <= 1'b0;                                   // reported once, then cleared
      end
  end

  // reset words stand until the first read of each channel
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      boot <= 2'b11;
    else
      for (int i = 0; i < 2; i++)
        if (rd_ch[i])
          boot[i] <= 1'b0;
  end

  // setup register; lengths outside 8..11 are refused with an error
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl <= SBRF_CTRL_RST[7:0];
    else if (access && pwrite && paddr == SBRF_CTRL_OFF
             && pwdata[3:0] >= SBRF_LEN_MIN && pwdata[3:0] <= SBRF_LEN_MAX)
      ctrl <= pwdata[7:0];
  end

  // channel 1 reset word: config report of the setup, odd parity
  function automatic logic [15:0] sbrf_cfg_word(input logic [7:0] c);
    logic [15:0] w;
    w = {cfg_bits, 2'b00, 4'h0, c};
    w[13] = ~^w;
    return w;
  endfunction : sbrf_cfg_word

  // channel read value: reset word, buffer head, or empty value
  function automatic logic [15:0] sbrf_ch_word(input int i);
    logic [15:0] w;
    if (boot[i])
      w = (i == 0) ? sbrf_cfg_word(ctrl) : SBRF_CH2_RST;
    else if (out_valid[i])
    begin
      w     = out_data[i];                                   // stored word
      w[12] = out_data[i][12] | lost[i];                     // drop shown on next read
      w[13] = 1'b0;                                          // cleared before parity
      w[13] = ~^w;                                           // parity covers new d12
    end
    else
    begin
      w = {st[i], 14'h0000};                                 // empty: no faults
      w[13] = ~^w;
    end
    return w;
  endfunction : sbrf_ch_word

  // apb answer registered in the setup cycle, ready in access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (setup)
      begin
        unique case (paddr)
          SBRF_CTRL_OFF: prdata <= {24'h000000, ctrl};
          SBRF_CH1_OFF:  prdata <= {16'h0000, sbrf_ch_word(0)};
          SBRF_CH2_OFF:  prdata <= {16'h0000, sbrf_ch_word(1)};
          SBRF_STAT_OFF: prdata <= {16'h0000, 8'(level[1]), 8'(level[0])};
          default:       pslverr <= 1'b1;                    // unmapped address
        endcase
        if (pwrite && paddr == SBRF_CTRL_OFF
            && !(pwdata[3:0] >= SBRF_LEN_MIN && pwdata[3:0] <= SBRF_LEN_MAX))
          pslverr <= 1'b1;
      end
    end
  end

  // assertions
  par_odd_a: assert property (@(posedge pclk) disable iff (!presetn)
    in_valid[0] |-> ^in_data[0]) else $error("even parity word");
  code_par_a: assert property (@(posedge pclk) disable iff (!presetn)
    msg_valid && msg.par_err |-> body == 12'h01c) else $error("parity code");
  code_many_a: assert property (@(posedge pclk) disable iff (!presetn)
    msg_valid && !msg.par_err && msg.nbits > {1'b0, field_len}
    |-> body == 12'h01a) else $error("many code");
  code_few_a: assert property (@(posedge pclk) disable iff (!presetn)
    msg_valid && !msg.par_err && msg.nbits < {1'b0, field_len}
    |-> body == 12'h019) else $error("few code");
  data_d11_a: assert property (@(posedge pclk) disable iff (!presetn)
    msg_valid && body[11] |-> !msg.par_err && !msg.time_err
    && msg.nbits == {1'b0, field_len}) else $error("d11 on fault");
  just_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    msg_valid && body[11] |-> (body[10:0] >> field_len) == 11'h0)
    else $error("upper bits set");
  len_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    field_len >= 4'h8 && field_len <= 4'hb) else $error("length range");
  lost_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    in_valid[0] && !in_ready[0] |=> lost[0]) else $error("loss missed");
  ch2_boot_a: assert property (@(posedge pclk) disable iff (!presetn)
    boot[1] && psel && !penable && !pwrite && paddr == 8'h08
    |=> prdata == 32'h0000_e000) else $error("ch2 reset word");
  status_a: assert property (@(posedge pclk) disable iff (!presetn)
    in_valid[1] |-> in_data[1][15:14] == 2'b10) else $error("status bits");
  ch1_cfg_a: assert property (@(posedge pclk) disable iff (!presetn)
    boot[0] && psel && !penable && paddr == 8'h04
    |=> prdata[15:14] == 2'b11 && ^prdata[15:0]) else $error("ch1 word");

  // a drop must show up in d12 of the next word read out
  lost_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && paddr == SBRF_CH1_OFF && !boot[0] && out_valid[0] && lost[0]
    |=> prdata[12]) else $error("loss not shown");
  // a bit time error alone is reported with the too few code
  code_time_a: assert property (@(posedge pclk) disable iff (!presetn)
    msg_valid && !msg.par_err && msg.nbits == {1'b0, field_len} && msg.time_err
    |-> body == SBRF_CODE_FEW) else $error("time code");

  // main scenarios
  fill_c: cover property (@(posedge pclk) disable iff (!presetn) !in_ready[0]);
  lost_c: cover property (@(posedge pclk) disable iff (!presetn) lost[0]);
  boot_c: cover property (@(posedge pclk) disable iff (!presetn)
    rd_ch[0] && boot[0]);
  many_c: cover property (@(posedge pclk) disable iff (!presetn)
    msg_valid && body == 12'h01a);
  data_c: cover property (@(posedge pclk) disable iff (!presetn) out_ready[1]);
endmodule : sbrf_formatter
`default_nettype wire

// ===== testbench/sbrf_sensor_model.sv
// file: behavioural source of decoded satellite messages
`timescale 1ns/1ns
`default_nettype none
module sbrf_sensor_model
  import sbrf_pkg::*;
(
  input  wire logic      pclk,
  input  wire logic      msg_ready,
  output var sbrf_msg_t  msg,
  output var logic       msg_valid
);
  // quiet until the bench asks for a message
  initial
  begin
    msg       = '0;
    msg_valid = 1'b0;
  end
  // one-cycle pulse; the fields are inverted afterwards so stale values never look valid
  task automatic send(input logic ch, input logic [4:0] nb, input logic [10:0] dt,
                      input logic pe, input logic te);
    @(posedge pclk);
    msg       <= '{chan: ch, nbits: nb, data: dt, par_err: pe, time_err: te};
    msg_valid <= msg_ready;
    @(posedge pclk);
    msg_valid <= 1'b0;
    msg       <= ~msg;
  endtask : send
endmodule : sbrf_sensor_model
`default_nettype wire

// ===== testbench/test_satellite_b_report_formatter.sv
// file: self-checking bench for the satellite report formatter
`timescale 1ns/1ns
`default_nettype none
module test_satellite_b_report_formatter
  import sbrf_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        msg_valid, msg_ready;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [3:0]  len;              // field length under test
  logic [4:0]  nb;               // bit count sent
  sbrf_msg_t   msg;
  logic [11:0] q [$];            // payloads expected from the buffer
  int          n_errors, checks_done, cycles;

  sbrf_formatter u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .msg(msg), .msg_valid(msg_valid), .msg_ready(msg_ready));
  sbrf_sensor_model u_sensor (.pclk(pclk), .msg_ready(msg_ready), .msg(msg),
    .msg_valid(msg_valid));

  // free-running 100 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // hang guard: counts a mismatch and closes the run
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      summarize();
    end
  end

  // xorshift step, repeatable from the fixed seed
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // report word: status, odd parity over the whole word, lost flag, payload
  function automatic logic [31:0] word(input logic [1:0] st, input logic lost,
                                       input logic [11:0] pay);
    return {16'h0, st, ~^{st, lost, pay}, lost, pay};
  endfunction : word

  // payload for a message; parity wins over too many, which wins over too few
  function automatic logic [11:0] pay_of(input logic [3:0] l, input logic [4:0] n,
    input logic [10:0] dt, input logic pe, input logic te);
    if (pe)
      return SBRF_CODE_PAR;
    if (n > {1'b0, l})
      return SBRF_CODE_MANY;
    if (n < {1'b0, l} || te)
      return SBRF_CODE_FEW;
    return {1'b1, dt & ((11'h1 << l) - 11'h1)};
  endfunction : pay_of

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // one apb transfer; answer taken at the edge where pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  // main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {n_errors, checks_done, cycles} = '0;
    seed = 32'h00640272;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, SBRF_CH2_OFF, 32'h0);
    check("ch2 reset word", rd, 32'h0000_e000);
    apb(1'b0, SBRF_CH1_OFF, 32'h0);
    check("ch1 reset word", rd, word(2'b11, 1'b0, {4'h0, SBRF_CTRL_RST[7:0]}));
    // lengths just outside the legal span are refused
    apb(1'b1, SBRF_CTRL_OFF, 32'h0000_00a7);
    check("length 7 refused", {31'h0, err}, 32'h1);
    apb(1'b1, SBRF_CTRL_OFF, 32'h0000_00ac);
    check("length 12 refused", {31'h0, err}, 32'h1);
    apb(1'b0, SBRF_CTRL_OFF, 32'h0);
    check("control kept", rd, SBRF_CTRL_RST);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped refused", {31'h0, err}, 32'h1);
    $display("test reset and refusals done");
    // every length, exact, long, short, timing and parity cases on random channels
    for (int l = 8; l <= 11; l++)
    begin
      len = 4'(l);
      apb(1'b1, SBRF_CTRL_OFF, {24'h0, 4'ha, len});
      check("length accepted", {31'h0, err}, 32'h0);
      for (int k = 0; k < 6; k++)
      begin
        seed = xs(seed);
        nb = (k == 1 || k == 4) ? 5'(len) + 5'h1 : (k == 2) ? 5'(len) - 5'h1 : 5'(len);
        u_sensor.send(seed[0], nb, seed[11:1], k == 4, k == 3);
        apb(1'b0, seed[0] ? SBRF_CH2_OFF : SBRF_CH1_OFF, 32'h0);
        check("message word", rd, word(2'b10, 1'b0,
              pay_of(len, nb, seed[11:1], k == 4, k == 3)));
      end
    end
    $display("test lengths and faults done");
    // overflow: seventeen words into a sixteen-word buffer
    apb(1'b1, SBRF_CTRL_OFF, 32'h0000_00a8);
    for (int i = 0; i < 17; i++)
    begin
      seed = xs(seed);
      u_sensor.send(1'b0, 5'h8, seed[10:0], 1'b0, 1'b0);
      q.push_back(pay_of(4'h8, 5'h8, seed[10:0], 1'b0, 1'b0));
    end
    for (int i = 0; i < 17; i++)
    begin
      apb(1'b0, SBRF_CH1_OFF, 32'h0);
      check("drained word", rd, word(2'b10, i == 0, (i == 16) ? 12'h0 : q[i]));
    end
    $display("test overflow done");
    // channel 1 without processing, channel 2 off: messages are not stored
    apb(1'b1, SBRF_CTRL_OFF, 32'h0000_0018);
    u_sensor.send(1'b0, 5'h8, 11'h0ff, 1'b0, 1'b0);
    u_sensor.send(1'b1, 5'h8, 11'h0ff, 1'b0, 1'b0);
    apb(1'b0, SBRF_CH1_OFF, 32'h0);
    check("no processing word", rd, word(2'b01, 1'b0, 12'h0));
    apb(1'b0, SBRF_CH2_OFF, 32'h0);
    check("channel off word", rd, word(2'b00, 1'b0, 12'h0));
    $display("test channel states done");
    // reset in mid run: both channels fall back to their reset words
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, SBRF_CH2_OFF, 32'h0);
    check("ch2 word after reset", rd, 32'h0000_e000);
    apb(1'b0, SBRF_CH1_OFF, 32'h0);
    check("ch1 word after reset", rd, word(2'b11, 1'b0, {4'h0, SBRF_CTRL_RST[7:0]}));
    $display("test mid-run reset done");
    summarize();
  end
endmodule : test_satellite_b_report_formatter
`default_nettype wire
